// ---- logic/adc_regs_pkg.sv ----
// constants for the range-select and alarm-status register bank
//==============================================================
// Overview of operation
// [R01] reserved bits of both registers read zero
// [R02] bit 6 switches internal reference off
// [R03] bits 3-0 hold range code, reset zero
// [R04] bipolar codes 0-4 map five ranges
// [R05] unipolar codes 8-b map four ranges
// [R06] bit 15 follows low supply condition
// [R07] bit 14 follows high supply condition
// [R08] bits 11 and 10 follow input alarms
// [R09] bits 7 and 6 latch supply alarms
// [R10] bits 5 and 4 latch input alarms
// [R11] bit 0 is OR of latched flags
// [R12] range register at bytes 14h-17h
// [R13] alarm register at bytes 20h-23h, read-only
// [R14] latched flags hold until alarm read
// [R15] host writes only the nine codes
package adc_regs_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] RANGE_BASE = 8'h14;
   localparam logic [7:0] ALARM_BASE = 8'h20;
   localparam logic [7:0] MASK_BASE = 8'h30;
   localparam logic [1:0] LANE_MASK = 2'h3;
   localparam int RANGE_LSB = 0;
   localparam int RANGE_W = 4;
   localparam int REFOFF_BIT = 6;
   localparam int SUP_LOW_ACT_BIT = 15;
   localparam int SUP_HIGH_ACT_BIT = 14;
   localparam int IN_B11_ACT_BIT = 11;
   localparam int IN_B10_ACT_BIT = 10;
   localparam int SUP_LOW_LAT_BIT = 7;
   localparam int SUP_HIGH_LAT_BIT = 6;
   localparam int IN_B5_LAT_BIT = 5;
   localparam int IN_B4_LAT_BIT = 4;
   localparam int ANY_LAT_BIT = 0;
   localparam logic [3:0] RANGE_RESET = 4'h0;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   // range codes
   localparam logic [3:0] BIP_3X = 4'h0;
   localparam logic [3:0] BIP_2P5X = 4'h1;
   localparam logic [3:0] BIP_1P5X = 4'h2;
   localparam logic [3:0] BIP_1P25X = 4'h3;
   localparam logic [3:0] BIP_0P625X = 4'h4;
   localparam logic [3:0] UNI_3X = 4'h8;
   localparam logic [3:0] UNI_2P5X = 4'h9;
   localparam logic [3:0] UNI_1P5X = 4'ha;
   localparam logic [3:0] UNI_1P25X = 4'hb;
   typedef enum logic [2:0] {SPAN_3X, SPAN_2P5X, SPAN_1P5X, SPAN_1P25X, SPAN_0P625X} span_t;
endpackage : adc_regs_pkg

// ---- logic/adc_range_and_alarm_status_regs.sv ----
// register bank: input range select, alarm flags, interrupt mask
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module adc_range_and_alarm_status_regs
   import adc_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic supplyLowPin,
   input wire logic supplyHighPin,
   input wire logic inputAlarmB11Pin,
   input wire logic inputAlarmB10Pin,
   output logic internal_reference_off,
   output logic [3:0] rangeCode,
   output logic rangeBipolar,
   output logic rangeValid,
   output span_t rangeSpan,
   output logic irq
);
   //==============================================================
   // reset release and pin synchronisers
   logic [1:0] rstSync;
   logic rstLocal_n;
   logic [3:0] condMeta;
   logic [3:0] cond;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstLocal_n = rstSync[1];

   // order: supply low, supply high, input b11, input b10
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         condMeta <= 4'h0;
         cond <= 4'h0;
      end else begin
         condMeta <= {supplyLowPin, supplyHighPin, inputAlarmB11Pin, inputAlarmB10Pin};
         cond <= condMeta;
      end
   end

   //==============================================================
   // address decode
   logic [5:0] wordAddr;
   logic [1:0] lane;
   logic hitRange;
   logic hitAlarm;
   logic hitMask;
   assign wordAddr = regAddr[ADDR_W-1:2];
   assign lane = regAddr[1:0] & LANE_MASK;
   assign hitRange = (wordAddr == RANGE_BASE[ADDR_W-1:2]); // see [R12]
   assign hitAlarm = (wordAddr == ALARM_BASE[ADDR_W-1:2]); // see [R13]
   assign hitMask = (wordAddr == MASK_BASE[ADDR_W-1:2]);

   //==============================================================
   // range select register
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         rangeCode <= RANGE_RESET;
         internal_reference_off <= 1'b0;
      end else if (regWrite && hitRange && lane == 2'h0) begin
         rangeCode <= regWrData[RANGE_LSB +: RANGE_W]; // see [R03]
         internal_reference_off <= regWrData[REFOFF_BIT]; // see [R02]
      end
   end

   // decode is registered beside the code, so all range outputs move on one edge
   logic [3:0] next_rangeCode;
   logic next_rangeBipolar;
   logic next_rangeValid;
   span_t next_rangeSpan;
   logic rangeWrite;
   assign rangeWrite = regWrite && hitRange && lane == 2'h0;

   always_comb begin
      next_rangeCode = rangeCode;
      if (rangeWrite) begin
         next_rangeCode = regWrData[RANGE_LSB +: RANGE_W];
      end
   end

   // codes outside the nine are left to the host to avoid; flagged invalid
   always_comb begin
      next_rangeBipolar = 1'b1;
      next_rangeValid = 1'b1;
      next_rangeSpan = SPAN_3X;
      case (next_rangeCode)
         BIP_3X: next_rangeSpan = SPAN_3X; // see [R04]
         BIP_2P5X: next_rangeSpan = SPAN_2P5X;
         BIP_1P5X: next_rangeSpan = SPAN_1P5X;
         BIP_1P25X: next_rangeSpan = SPAN_1P25X;
         BIP_0P625X: next_rangeSpan = SPAN_0P625X;
         UNI_3X: begin
            next_rangeBipolar = 1'b0; // see [R05]
            next_rangeSpan = SPAN_3X;
         end
         UNI_2P5X: begin
            next_rangeBipolar = 1'b0;
            next_rangeSpan = SPAN_2P5X;
         end
         UNI_1P5X: begin
            next_rangeBipolar = 1'b0;
            next_rangeSpan = SPAN_1P5X;
         end
         UNI_1P25X: begin
            next_rangeBipolar = 1'b0;
            next_rangeSpan = SPAN_1P25X;
         end
         default: next_rangeValid = 1'b0; // see [R15]
      endcase
   end

   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         rangeBipolar <= 1'b1;
         rangeValid <= 1'b1;
         rangeSpan <= SPAN_3X;
      end else begin
         rangeBipolar <= next_rangeBipolar; // see [R04] [R05]
         rangeValid <= next_rangeValid;
         rangeSpan <= next_rangeSpan;
      end
   end

   //==============================================================
   // latched alarm flags and interrupt mask
   logic [3:0] latched;
   logic [3:0] irqMask;
   logic alarmRead;
   assign alarmRead = regRead && hitAlarm && lane == 2'h0;

   // a new condition in the clearing cycle wins over the clear
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         latched <= LATCH_RESET;
      end else if (alarmRead) begin
         latched <= cond; // see [R14]
      end else begin
         latched <= latched | cond; // see [R09] [R10]
      end
   end

   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         irqMask <= 4'h0;
      end else if (regWrite && hitMask && lane == 2'h0) begin
         irqMask <= regWrData[3:0];
      end
   end

   assign irq = |(latched & irqMask);

   //==============================================================
   // register images and read path
   logic [31:0] rangeImage;
   logic [31:0] alarmImage;
   logic [31:0] maskImage;
   logic [31:0] readWord;

   always_comb begin
      rangeImage = 32'h0; // see [R01]
      rangeImage[RANGE_LSB +: RANGE_W] = rangeCode;
      rangeImage[REFOFF_BIT] = internal_reference_off;
      alarmImage = 32'h0; // see [R01]
      alarmImage[SUP_LOW_ACT_BIT] = cond[3]; // see [R06]
      alarmImage[SUP_HIGH_ACT_BIT] = cond[2]; // see [R07]
      alarmImage[IN_B11_ACT_BIT] = cond[1]; // see [R08]
      alarmImage[IN_B10_ACT_BIT] = cond[0];
      alarmImage[SUP_LOW_LAT_BIT] = latched[3]; // see [R09]
      alarmImage[SUP_HIGH_LAT_BIT] = latched[2];
      alarmImage[IN_B5_LAT_BIT] = latched[1]; // see [R10]
      alarmImage[IN_B4_LAT_BIT] = latched[0];
      alarmImage[ANY_LAT_BIT] = |latched; // see [R11]
      maskImage = {28'h0, irqMask};
      if (hitRange) begin
         readWord = rangeImage;
      end else if (hitAlarm) begin
         readWord = alarmImage;
      end else if (hitMask) begin
         readWord = maskImage;
      end else begin
         readWord = 32'h0;
      end
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         regRdData <= 8'h0;
      end else if (regRead) begin
         regRdData <= readWord[{lane, 3'h0} +: 8]; // see [R12] [R13]
      end else begin
         regRdData <= 8'h0;
      end
   end

   //==============================================================
   // checks
   sequence s_alarmRd;
      regRead && hitAlarm && lane == 2'h0;
   endsequence

   a_any_latch_or: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R11]
      s_alarmRd |=> regRdData[ANY_LAT_BIT] == |regRdData[IN_B4_LAT_BIT +: 4])
      else $error("summary bit differs from OR of latched flags");
   a_latch_holds: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R14]
      (latched[3] && !alarmRead) |=> latched[3])
      else $error("latched supply-low flag dropped without a read");
   a_latch_sets: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R09]
      cond[2] |=> latched[2])
      else $error("supply-high condition not latched");
   a_range_write: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R03]
      (regWrite && hitRange && lane == 2'h0) |=> rangeCode == $past(regWrData[3:0]))
      else $error("range code not stored");
   a_refoff_write: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R02]
      (regWrite && hitRange && lane == 2'h0) |=> internal_reference_off == $past(regWrData[REFOFF_BIT]))
      else $error("reference-off bit not stored");
   a_range_rsvd: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R01]
      (regRead && hitRange && lane == 2'h0) |=> regRdData[7] == 1'b0 && regRdData[5:4] == 2'h0)
      else $error("reserved range bits not zero");
   a_alarm_upper: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R13]
      (regRead && hitAlarm && lane[1]) |=> regRdData == 8'h0)
      else $error("alarm upper bytes not zero");
   a_active_follow: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R06]
      (regRead && hitAlarm && lane == 2'h1) |=> regRdData[7] == $past(cond[3]) && regRdData[5:4] == 2'h0)
      else $error("active supply-low flag wrong");
   a_unipolar: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R05]
      rangeCode == UNI_1P25X |-> !rangeBipolar && rangeSpan == SPAN_1P25X)
      else $error("unipolar decode wrong");
   a_bipolar: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04]
      rangeCode == BIP_0P625X |-> rangeBipolar && rangeSpan == SPAN_0P625X)
      else $error("bipolar decode wrong");

   // active byte read, bits 15-8
   sequence s_activeRd;
      regRead && hitAlarm && lane == 2'h1;
   endsequence
   a_uni_3x: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R05]
      rangeCode == UNI_3X |-> !rangeBipolar && rangeValid && rangeSpan == SPAN_3X)
      else $error("unipolar 3x decode wrong");
   a_uni_2p5: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R05]
      rangeCode == UNI_2P5X |-> !rangeBipolar && rangeValid && rangeSpan == SPAN_2P5X)
      else $error("unipolar 2.5x decode wrong");
   a_uni_1p5: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R05]
      rangeCode == UNI_1P5X |-> !rangeBipolar && rangeValid && rangeSpan == SPAN_1P5X)
      else $error("unipolar 1.5x decode wrong");
   a_bip_3x: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04]
      rangeCode == BIP_3X |-> rangeBipolar && rangeValid && rangeSpan == SPAN_3X)
      else $error("bipolar 3x decode wrong");
   a_bip_2p5: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04]
      rangeCode == BIP_2P5X |-> rangeBipolar && rangeValid && rangeSpan == SPAN_2P5X)
      else $error("bipolar 2.5x decode wrong");
   a_bip_1p5: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04]
      rangeCode == BIP_1P5X |-> rangeBipolar && rangeValid && rangeSpan == SPAN_1P5X)
      else $error("bipolar 1.5x decode wrong");
   a_bip_1p25: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04]
      rangeCode == BIP_1P25X |-> rangeBipolar && rangeValid && rangeSpan == SPAN_1P25X)
      else $error("bipolar 1.25x decode wrong");
   a_invalid_code: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R15]
      !rangeValid |-> rangeBipolar && rangeSpan == SPAN_3X)
      else $error("fallback decode of unlisted code wrong");
   a_valid_codes: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R04] [R05]
      rangeValid |-> (rangeCode <= BIP_0P625X) || (rangeCode >= UNI_3X && rangeCode <= UNI_1P25X))
      else $error("unlisted code flagged valid");
   a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R02] [R03]
      !rangeWrite |=> $stable(rangeCode) && $stable(internal_reference_off))
      else $error("range register changed without a byte 0 write");
   a_range_upper: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R01]
      (regRead && hitRange && lane != 2'h0) |=> regRdData == 8'h0)
      else $error("range upper bytes not zero");
   a_active_high: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R07]
      s_activeRd |=> regRdData[6] == $past(cond[2]))
      else $error("active supply-high flag wrong");
   a_active_inputs: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R08]
      s_activeRd |=> regRdData[3] == $past(cond[1]) && regRdData[2] == $past(cond[0]) && regRdData[1:0] == 2'h0)
      else $error("active input flags wrong");
   a_latch_byte: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R09] [R10]
      s_alarmRd |=> regRdData[IN_B4_LAT_BIT +: 4] == $past(latched))
      else $error("latched flags read back wrong");
   a_alarm_rsvd: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R01]
      s_alarmRd |=> regRdData[3:1] == 3'h0)
      else $error("reserved alarm bits not zero");
   a_summary_live: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R11]
      s_alarmRd |=> regRdData[ANY_LAT_BIT] == |$past(latched))
      else $error("summary bit does not match latched flags");
   a_read_clear: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R14]
      s_alarmRd |=> latched == $past(cond))
      else $error("alarm read did not reload latched flags");
   a_latch_no_drop: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R14]
      !alarmRead |=> (latched & $past(latched)) == $past(latched))
      else $error("latched flag dropped without a read");
   a_latch_low: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R09]
      cond[3] |=> latched[3])
      else $error("supply-low condition not latched");
   a_latch_in_b5: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R10]
      cond[1] |=> latched[1])
      else $error("input b11 condition not latched");
   a_latch_in_b4: assert property (@(posedge core_clk) disable iff (!rstLocal_n) // see [R10]
      cond[0] |=> latched[0])
      else $error("input b10 condition not latched");
endmodule : adc_range_and_alarm_status_regs

// ---- verif/alarm_condition_model.sv ----
// analog condition source standing in for the supply and input comparators
`timescale 1ns/100ps
module alarm_condition_model (
   input wire logic core_clk,
   input wire logic [3:0] want,
   output logic [3:0] pins
);
   // comparators settle off the clock grid, so edges reach the block 1 ns after a rising clock edge
   initial begin
      pins = 4'h0;
      forever @(posedge core_clk) pins <= #1 want;
   end
endmodule : alarm_condition_model

// ---- verif/adc_range_and_alarm_status_regs_tb.sv ----
// self-checking bench for the range select and alarm status bank
`timescale 1ns/100ps
module adc_range_and_alarm_status_regs_tb;
   import adc_regs_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdDly = 1'b0;
   logic irq, refOff, bip, valid, v;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, ex;
   logic [3:0] want = 4'h0, pins, rangeCode, p;
   span_t rangeSpan;
   logic [7:0] expQ[$];
   int badCount = 0, samplesChecked = 0, cycles = 0;
   always #2 core_clk = ~core_clk;
   alarm_condition_model i_pins (.core_clk(core_clk), .want(want), .pins(pins));
   adc_range_and_alarm_status_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .supplyLowPin(pins[3]), .supplyHighPin(pins[2]), .inputAlarmB11Pin(pins[1]),
      .inputAlarmB10Pin(pins[0]), .internal_reference_off(refOff), .rangeCode(rangeCode),
      .rangeBipolar(bip), .rangeValid(valid), .rangeSpan(rangeSpan), .irq(irq));
   //==============================================================
   // bus tasks and comparison
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      samplesChecked++;
      if (s !== e) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   task automatic chkOut(input string what, input logic [7:0] e, input logic [7:0] s);
      samplesChecked++;
      if (s !== e) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chkOut
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
   endtask : rd
   task automatic results();
      if (badCount == 0 && samplesChecked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   //==============================================================
   // read data watcher, timeout
   always @(posedge core_clk) rdDly <= regRead;
   always @(negedge core_clk) begin
      if (rdDly) chk("regRdData", expQ.pop_front(), regRdData);
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         results();
      end
   end
   //==============================================================
   // scenarios
   initial begin
      void'($urandom(67065));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int a = 0; a < 4; a++) begin
         rd(8'h14 + 8'(a), 8'h00);
         rd(8'h20 + 8'(a), 8'h00);
      end
      rd(8'h40, 8'h00);
      // codes outside the nine are probed too, against the chosen fallback
      for (int c = 0; c < 16; c++) begin
         ex = (8'($urandom) & 8'hb0) | 8'(c);
         ex[6] = c[0];
         wr(8'h14, ex);
         @(negedge core_clk);
         v = (c < 5) || (c > 7 && c < 12);
         chkOut("rangeCode", 8'(c), {4'h0, rangeCode});
         chkOut("refOff", {7'h0, ex[6]}, {7'h0, refOff});
         chkOut("valid", {7'h0, v}, {7'h0, valid});
         chkOut("bipolar", {7'h0, !v || c < 8}, {7'h0, bip});
         chkOut("span", v ? 8'(c % 8) : 8'h00, {5'h0, rangeSpan});
         rd(8'h14, ex & 8'h4f);
         wr(8'h15 + 8'(c % 3), 8'($urandom));
         rd(8'h15 + 8'(c % 3), 8'h00);
      end
      wr(8'h30, 8'h08);
      for (int k = 0; k < 8; k++) begin
         p = 4'($urandom);
         want <= p;
         repeat (4) @(posedge core_clk);
         @(negedge core_clk);
         chkOut("irq", {7'h0, p[3]}, {7'h0, irq});
         rd(8'h21, {p[3:2], 2'b00, p[1:0], 2'b00});
         want <= 4'h0;
         repeat (4) @(posedge core_clk);
         rd(8'h21, 8'h00);
         wr(8'h20, 8'hff);
         rd(8'h20, {p, 3'b000, |p});
         rd(8'h20, 8'h00);
      end
      repeat (3) @(posedge core_clk);
      results();
   end
endmodule : adc_range_and_alarm_status_regs_tb
